// *** src/swdt_pkg.sv ***
// Shared constants of the supervisory timer and its register bridge
package swdt_pkg;
  // ************************************************************
  // Control byte layout
  // ************************************************************
  localparam int CTRL_W          = 8;
  localparam int IRQ_FLAG_BIT    = 7;
  localparam int IRQ_EN_BIT      = 6;
  localparam int PERIOD_HI_BIT   = 5;
  localparam int CHANGE_EN_BIT   = 4;
  localparam int RESET_EN_BIT    = 3;
  localparam int PERIOD_LO_MSB   = 2;
  localparam int PERIOD_W        = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CHANGE_WINDOW_CYCLES = 4;
  localparam int OSC_FREQ_KHZ         = 128;
  localparam int TIMEOUT_BASE_CYCLES  = 2048;
  localparam int MAX_PERIOD_SEL       = 9;
  localparam int MIN_TIMEOUT_MS       = 16;
  localparam int MAX_TIMEOUT_MS       = 8000;
  localparam int STARTUP_DELAY_CYCLES = 64;

  // ************************************************************
  // Bridge register map and command bits
  // ************************************************************
  localparam logic [7:0] CMD_OFS    = 8'h00;
  localparam logic [7:0] CTRL_OFS   = 8'h04;
  localparam logic [7:0] FLAG_OFS   = 8'h08;
  localparam logic [7:0] STATUS_OFS = 8'h0c;
  localparam logic [7:0] PROT_OFS   = 8'h10;
  localparam int CMD_RESTART_BIT    = 0;
  localparam int CMD_VECTOR_BIT     = 1;

  typedef enum logic [1:0] {SWDT_SEQ_IDLE, SWDT_SEQ_OPEN, SWDT_SEQ_SET} swdt_seq_e;
endpackage

// *** src/swdt_if.sv ***
// Link between the processor-side bridge and the supervisory timer
`timescale 1ns/1ps
`default_nettype none
interface swdt_if;
  logic       restart;
  logic       ctrl_wr;
  logic [7:0] ctrl_wdata;
  logic       flag_wr;
  logic       flag_wdata;
  logic       vector_ack;
  logic [7:0] ctrl_rdata;
  logic       reset_flag;
  logic       irq;

  modport dev  (input restart, ctrl_wr, ctrl_wdata, flag_wr, flag_wdata, vector_ack,
                output ctrl_rdata, reset_flag, irq);
  modport host (output restart, ctrl_wr, ctrl_wdata, flag_wr, flag_wdata, vector_ack,
                input ctrl_rdata, reset_flag, irq);
endinterface
`default_nettype wire

// *** src/swdt_device.sv ***
// Supervisory timer with interrupt and one-cycle system reset on timeout
// What this block does
// - Reset action gives exactly one-cycle reset pulse
// - Startup delay starts at reset pulse falling edge
// - Counter advances on dedicated 128 kHz oscillator
// - Timeout value reached issues interrupt or reset
// - Restart instruction clears counter before timeout
// - Interrupt mode raises wake-capable interrupt on expiry
// - Reset mode asserts system reset on expiry
// - Combined mode: interrupt first, then reset
// - Always-on fuse forces reset mode
// - Fuse: reset enable reads 1, irq enable 0
// - Software opens change with change and reset enable
// - Within four cycles one write sets new values
// - Period select spans about 16ms to 8s
// - Restart before changing period select
// - After timeout reset, timer stays in reset mode
// - Init software clears reset flag, then enable
// - Change enable self-clears four cycles later
// - Reset flag forces reset enable set
// - Vector execution clears interrupt flag
// - Combined mode vector clears irq enable too
`timescale 1ns/1ps
`default_nettype none
module swdt_device #(
  parameter int TIMEOUT_BASE  = swdt_pkg::TIMEOUT_BASE_CYCLES,
  parameter int STARTUP_DELAY = swdt_pkg::STARTUP_DELAY_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic always_on_fuse,
  input  wire logic osc_pin,
  swdt_if.dev       link,
  output logic      sys_reset_pulse,
  output logic      startup_hold,
  output logic      wake_irq
);
  localparam int CNT_W = $clog2(TIMEOUT_BASE) + swdt_pkg::MAX_PERIOD_SEL + 1;
  localparam int DLY_W = $clog2(STARTUP_DELAY + 1) + 1;
  localparam int WIN_W = 3;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] fuse_sync;
  logic [1:0] osc_sync;
  logic       osc_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_sync <= 2'h0;
      osc_sync  <= 2'h0;
      osc_prev  <= 1'b0;
    end else begin
      fuse_sync <= {fuse_sync[0], always_on_fuse};
      osc_sync  <= {osc_sync[0], osc_pin};
      osc_prev  <= osc_sync[1];
    end
  end

  // ************************************************************
  // Control state
  // ************************************************************
  logic                 irq_flag;
  logic                 irq_en;
  logic                 reset_en;
  logic                 change_en;
  logic [WIN_W-1:0]     win_cnt;
  logic [3:0]           period;
  logic                 reset_flag;
  logic [CNT_W-1:0]     count;
  logic [DLY_W-1:0]     dly_cnt;

  wire logic fuse      = fuse_sync[1];
  wire logic osc_tick  = osc_sync[1] & ~osc_prev;
  wire logic eff_re    = fuse | reset_en | reset_flag;
  wire logic eff_ie    = ~fuse & irq_en;
  wire logic running   = eff_re | eff_ie;

  wire logic [3:0] sel = (period > 4'(swdt_pkg::MAX_PERIOD_SEL)) ?
                         4'(swdt_pkg::MAX_PERIOD_SEL) : period;
  wire logic [CNT_W-1:0] limit = CNT_W'(TIMEOUT_BASE) << sel;
  wire logic expire    = running & osc_tick & ~link.restart & (count >= limit - CNT_W'(1));
  wire logic combined  = eff_re & eff_ie;
  wire logic fire_irq  = expire & eff_ie & ~(combined & irq_flag);
  wire logic fire_rst  = expire & eff_re & (~eff_ie | irq_flag);

  // ************************************************************
  // Register writes from the core
  // ************************************************************
  wire logic [7:0] wd     = link.ctrl_wdata;
  wire logic wr           = link.ctrl_wr;
  wire logic wr_open      = wr & wd[swdt_pkg::CHANGE_EN_BIT] & wd[swdt_pkg::RESET_EN_BIT];
  wire logic wr_commit    = wr & ~wd[swdt_pkg::CHANGE_EN_BIT] & change_en;
  wire logic [3:0] wd_per = {wd[swdt_pkg::PERIOD_HI_BIT], wd[swdt_pkg::PERIOD_LO_MSB:0]};
  wire logic win_end      = change_en & (win_cnt == WIN_W'(swdt_pkg::CHANGE_WINDOW_CYCLES - 1));
  wire logic flag_clr     = wr & wd[swdt_pkg::IRQ_FLAG_BIT] | link.vector_ack;
  wire logic rf_clr       = link.flag_wr & ~link.flag_wdata;

  logic                 next_reset_en;
  logic [3:0]           next_period;
  logic                 next_irq_en;
  logic                 next_irq_flag;
  logic                 next_change_en;
  logic [DLY_W-1:0]     next_dly;
  // The pulse falls at the coming edge, so the stretch is loaded right there
  wire logic            pulse_fall = sys_reset_pulse & ~fire_rst;

  always_comb begin
    next_reset_en = reset_en;
    next_period   = period;
    next_irq_en   = irq_en;
    if (wr_commit) begin
      next_reset_en = wd[swdt_pkg::RESET_EN_BIT];
      next_period   = wd_per;
    end else if (wr & wd[swdt_pkg::RESET_EN_BIT]) begin
      next_reset_en = 1'b1;
    end
    if (reset_flag) begin
      next_reset_en = 1'b1;
    end
    if (wr) begin
      next_irq_en = wd[swdt_pkg::IRQ_EN_BIT];
    end
    if (link.vector_ack & combined) begin
      next_irq_en = 1'b0;
    end
    if (fire_irq) begin
      next_irq_flag = 1'b1;
    end else if (flag_clr) begin
      next_irq_flag = 1'b0;
    end else begin
      next_irq_flag = irq_flag;
    end
    if (wr_open) begin
      next_change_en = 1'b1;
    end else if (win_end | wr_commit) begin
      next_change_en = 1'b0;
    end else begin
      next_change_en = change_en;
    end
    if (pulse_fall) begin
      next_dly = DLY_W'(STARTUP_DELAY);
    end else if (dly_cnt != '0) begin
      next_dly = dly_cnt - DLY_W'(1);
    end else begin
      next_dly = dly_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_en  <= swdt_pkg::CTRL_RESET[swdt_pkg::RESET_EN_BIT];
      period    <= 4'h0;
      irq_en    <= 1'b0;
      irq_flag  <= 1'b0;
      change_en <= 1'b0;
    end else if (fire_rst) begin
      reset_en  <= 1'b1;
      period    <= 4'h0;
      irq_en    <= 1'b0;
      irq_flag  <= 1'b0;
      change_en <= 1'b0;
    end else begin
      reset_en  <= next_reset_en;
      period    <= next_period;
      irq_en    <= next_irq_en;
      irq_flag  <= next_irq_flag;
      change_en <= next_change_en;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt <= '0;
    end else if (wr_open | ~change_en) begin
      win_cnt <= '0;
    end else begin
      win_cnt <= win_cnt + WIN_W'(1);
    end
  end

  // ************************************************************
  // Timeout counter and reset flag
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (link.restart | expire | ~running) begin
      count <= '0;
    end else if (osc_tick) begin
      count <= count + CNT_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_flag <= 1'b0;
    end else if (fire_rst) begin
      reset_flag <= 1'b1;
    end else if (rf_clr) begin
      reset_flag <= 1'b0;
    end
  end

  // ************************************************************
  // Reset pulse, startup stretch and outputs
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_reset_pulse <= 1'b0;
      dly_cnt         <= '0;
      startup_hold    <= 1'b0;
      wake_irq        <= 1'b0;
      link.irq        <= 1'b0;
      link.reset_flag <= 1'b0;
      link.ctrl_rdata <= swdt_pkg::CTRL_RESET;
    end else begin
      sys_reset_pulse <= fire_rst;
      dly_cnt         <= next_dly;
      startup_hold    <= fire_rst | sys_reset_pulse | (next_dly != '0);
      wake_irq        <= irq_flag & eff_ie;
      link.irq        <= irq_flag & eff_ie;
      link.reset_flag <= reset_flag;
      link.ctrl_rdata <= {irq_flag, eff_ie, period[3], change_en,
                          eff_re, period[2:0]};
    end
  end
endmodule
`default_nettype wire

// *** src/swdt_host.sv ***
// Processor-side bridge: APB registers driving the supervisory timer link
`timescale 1ns/1ps
`default_nettype none
module swdt_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  swdt_if.host             link
);
  // ************************************************************
  // APB decode
  // ************************************************************
  swdt_pkg::swdt_seq_e seq;
  logic [7:0]          prot_val;

  wire logic access   = psel & penable & ~pready;
  wire logic done     = psel & penable & pready;
  wire logic hit_cmd  = paddr == swdt_pkg::CMD_OFS;
  wire logic hit_ctrl = paddr == swdt_pkg::CTRL_OFS;
  wire logic hit_flag = paddr == swdt_pkg::FLAG_OFS;
  wire logic hit_stat = paddr == swdt_pkg::STATUS_OFS;
  wire logic hit_prot = paddr == swdt_pkg::PROT_OFS;
  wire logic hit      = hit_cmd | hit_ctrl | hit_flag | hit_stat | hit_prot;
  wire logic busy     = seq != swdt_pkg::SWDT_SEQ_IDLE;
  wire logic wdone    = done & pwrite & ~pslverr;
  wire logic start    = wdone & hit_prot & ~busy;
  wire logic [31:0] rd_mux =
      hit_ctrl ? {24'h000000, link.ctrl_rdata} :
      hit_flag ? {31'h00000000, link.reset_flag} :
      hit_stat ? {30'h00000000, busy, link.irq} :
      hit_prot ? {24'h000000, prot_val} : 32'h00000000;

  // Opening write keeps the period so no early timeout occurs
  wire logic [7:0] open_val = link.ctrl_rdata
                              | (8'h01 << swdt_pkg::CHANGE_EN_BIT)
                              | (8'h01 << swdt_pkg::RESET_EN_BIT);
  wire logic [7:0] set_val  = prot_val & ~(8'h01 << swdt_pkg::CHANGE_EN_BIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access & ~hit;
      prdata  <= access ? rd_mux : 32'h00000000;
    end
  end

  // ************************************************************
  // Protected change sequencer
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq      <= swdt_pkg::SWDT_SEQ_IDLE;
      prot_val <= 8'h00;
    end else begin
      case (seq)
        swdt_pkg::SWDT_SEQ_IDLE: begin
          if (start) begin
            seq      <= swdt_pkg::SWDT_SEQ_OPEN;
            prot_val <= pwdata[7:0];
          end
        end
        swdt_pkg::SWDT_SEQ_OPEN: seq <= swdt_pkg::SWDT_SEQ_SET;
        swdt_pkg::SWDT_SEQ_SET:  seq <= swdt_pkg::SWDT_SEQ_IDLE;
        default:                 seq <= swdt_pkg::SWDT_SEQ_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Link strobes
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.restart    <= 1'b0;
      link.vector_ack <= 1'b0;
      link.ctrl_wr    <= 1'b0;
      link.ctrl_wdata <= 8'h00;
      link.flag_wr    <= 1'b0;
      link.flag_wdata <= 1'b0;
    end else begin
      link.restart    <= start | wdone & hit_cmd & pwdata[swdt_pkg::CMD_RESTART_BIT];
      link.vector_ack <= wdone & hit_cmd & pwdata[swdt_pkg::CMD_VECTOR_BIT];
      link.flag_wr    <= wdone & hit_flag;
      link.flag_wdata <= pwdata[0];
      if (seq == swdt_pkg::SWDT_SEQ_OPEN) begin
        link.ctrl_wr    <= 1'b1;
        link.ctrl_wdata <= open_val;
      end else if (seq == swdt_pkg::SWDT_SEQ_SET) begin
        link.ctrl_wr    <= 1'b1;
        link.ctrl_wdata <= set_val;
      end else begin
        link.ctrl_wr    <= wdone & hit_ctrl & ~busy;
        link.ctrl_wdata <= pwdata[7:0];
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/swdt_checker.sv ***
// Concurrent checks on the supervisory timer's reset and interrupt outputs and on its link to the bridge
`timescale 1ns/1ps
`default_nettype none
module swdt_checker #(
  parameter int STARTUP_DELAY = 4
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       restart,
  input wire logic [7:0] ctrl_rdata,
  input wire logic       reset_flag,
  input wire logic       always_on_fuse,
  input wire logic       sys_reset_pulse,
  input wire logic       startup_hold,
  input wire logic       wake_irq
);
  logic [7:0] hold_cnt;
  logic [7:0] next_hold_cnt;

  // Counts stretch cycles after the pulse
  assign next_hold_cnt = sys_reset_pulse ? 8'h00 : hold_cnt + {7'h00, startup_hold};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hold_cnt <= 8'h00;
    else hold_cnt <= next_hold_cnt;
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pulse;
    sys_reset_pulse ##1 !sys_reset_pulse;
  endsequence
  sequence s_quiet;
    !sys_reset_pulse [*8];
  endsequence

  a_pulse_single: assert property ($rose(sys_reset_pulse) |-> s_pulse)
    else $error("reset pulse not exactly one cycle");
  a_hold_on_pulse: assert property (sys_reset_pulse |-> startup_hold)
    else $error("startup hold low during reset pulse");
  a_hold_length: assert property ($fell(startup_hold) |-> hold_cnt == 8'(STARTUP_DELAY))
    else $error("startup hold stretch has wrong length");
  a_flag_on_pulse: assert property (sys_reset_pulse |=> reset_flag)
    else $error("reset flag not set after reset pulse");
  a_flag_forces_en: assert property (reset_flag && $past(reset_flag) |-> ctrl_rdata[swdt_pkg::RESET_EN_BIT])
    else $error("reset enable reads 0 while reset flag set");
  a_window_closes: assert property ($rose(ctrl_rdata[swdt_pkg::CHANGE_EN_BIT])
    |-> ##[1:5] !ctrl_rdata[swdt_pkg::CHANGE_EN_BIT])
    else $error("change window stays open too long");
  a_fuse_locks: assert property (always_on_fuse [*6] |-> ctrl_rdata[swdt_pkg::RESET_EN_BIT]
    && !ctrl_rdata[swdt_pkg::IRQ_EN_BIT])
    else $error("fuse does not lock enable bits");
  a_irq_has_flag: assert property (wake_irq |-> ctrl_rdata[swdt_pkg::IRQ_FLAG_BIT]
    && ctrl_rdata[swdt_pkg::IRQ_EN_BIT])
    else $error("interrupt without flag and enable");
  a_restart_defers: assert property (restart |=> s_quiet)
    else $error("reset pulse soon after restart");
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench: bridge and supervisory timer joined over their link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        always_on_fuse;
  logic        osc_pin = 1'b0;
  logic        sys_reset_pulse;
  logic        startup_hold;
  logic        wake_irq;
  logic [3:0]  osc_div = 4'h0;
  logic [15:0] lfsr;
  logic [31:0] rd;
  logic [31:0] v;
  logic        err;
  int          n_fail;
  int          n_tests;
  int          n_pulse = 0;
  int          p0;

  swdt_if link ();
  swdt_host i_swdt_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  swdt_device #(.TIMEOUT_BASE(4), .STARTUP_DELAY(4)) i_swdt_device (.pclk(pclk), .presetn(presetn),
    .always_on_fuse(always_on_fuse), .osc_pin(osc_pin), .link(link), .sys_reset_pulse(sys_reset_pulse),
    .startup_hold(startup_hold), .wake_irq(wake_irq));
  swdt_checker #(.STARTUP_DELAY(4)) i_swdt_checker (.pclk(pclk), .presetn(presetn), .restart(link.restart),
    .ctrl_rdata(link.ctrl_rdata), .reset_flag(link.reset_flag), .always_on_fuse(always_on_fuse),
    .sys_reset_pulse(sys_reset_pulse), .startup_hold(startup_hold), .wake_irq(wake_irq));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Timer oscillator, ten core cycles a period
  always @(posedge pclk) begin
    osc_div <= (osc_div == 4'h9) ? 4'h0 : osc_div + 4'h1;
    osc_pin <= (osc_div < 4'h5);
    if (sys_reset_pulse === 1'b1) n_pulse <= n_pulse + 1;
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function automatic logic [31:0] ctrl_exp(input logic ie, input logic re, input logic [3:0] p);
    return {24'h0, 1'b0, ie, p[3], 1'b0, re, p[2:0]};
  endfunction

  task automatic conclude;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // The slave always inserts exactly one wait state
    chk("wait states", 32'h2, 32'(k));
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // Protected change; the sequencer is back in idle two cycles after completion
  task automatic prot(input logic [31:0] d);
    apb(1'b1, swdt_pkg::PROT_OFS, d);
    repeat (8) @(posedge pclk);
  endtask

  task automatic wait_for(input logic rst);
    int k;
    k = 0;
    while (k < 400 && (rst ? sys_reset_pulse : wake_irq) !== 1'b1) begin
      @(posedge pclk);
      k++;
    end
    chk("event", 32'h1, {31'h0, k < 400});
  endtask

  initial begin
    repeat (60000) @(posedge pclk);
    n_fail++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    always_on_fuse = 1'b0;
    n_fail = 0;
    n_tests = 0;
    lfsr = 16'h000d;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // ************************************************************
    // Reset values and unmapped access
    // ************************************************************
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    rdchk("ctrl reset", swdt_pkg::CTRL_OFS, 32'h0);
    $display("test reset done");
    // Period codes 0 to 9 through the protected sequence
    for (int i = 0; i < 10; i++) begin
      lfsr = lfsr_next(lfsr);
      v = ctrl_exp(lfsr[0], 1'b0, 4'(i));
      prot(v);
      rdchk("period", swdt_pkg::CTRL_OFS, v);
    end
    prot(32'h0);
    $display("test period done");
    // Interrupt mode
    prot(ctrl_exp(1'b1, 1'b0, 4'h0));
    wait_for(1'b0);
    rdchk("status irq", swdt_pkg::STATUS_OFS, 32'h1);
    chk("no reset", 32'h0, 32'(n_pulse));
    apb(1'b1, swdt_pkg::CMD_OFS, 32'h2);
    repeat (3) @(posedge pclk);
    rdchk("vector clear", swdt_pkg::CTRL_OFS, ctrl_exp(1'b1, 1'b0, 4'h0));
    prot(32'h0);
    $display("test interrupt done");
    // Reset mode, refused clear, restarts, expiry
    apb(1'b1, swdt_pkg::CTRL_OFS, 32'h8);
    apb(1'b1, swdt_pkg::CTRL_OFS, 32'h0);
    rdchk("unprotected clear", swdt_pkg::CTRL_OFS, 32'h8);
    p0 = n_pulse;
    repeat (6) begin
      repeat (15) @(posedge pclk);
      apb(1'b1, swdt_pkg::CMD_OFS, 32'h1);
    end
    chk("restart holds off", 32'(p0), 32'(n_pulse));
    wait_for(1'b1);
    repeat (3) @(posedge pclk);
    rdchk("reset flag", swdt_pkg::FLAG_OFS, 32'h1);
    rdchk("stays reset mode", swdt_pkg::CTRL_OFS, 32'h8);
    prot(32'h0);
    rdchk("flag forces enable", swdt_pkg::CTRL_OFS, 32'h8);
    apb(1'b1, swdt_pkg::FLAG_OFS, 32'h0);
    prot(32'h0);
    rdchk("disabled", swdt_pkg::CTRL_OFS, 32'h0);
    chk("one reset", 32'(p0 + 1), 32'(n_pulse));
    $display("test reset mode done");
    // Combined mode: interrupt, vector, then reset
    p0 = n_pulse;
    prot(ctrl_exp(1'b1, 1'b1, 4'h0));
    wait_for(1'b0);
    chk("irq first", 32'(p0), 32'(n_pulse));
    apb(1'b1, swdt_pkg::CMD_OFS, 32'h2);
    repeat (3) @(posedge pclk);
    rdchk("vector to reset", swdt_pkg::CTRL_OFS, ctrl_exp(1'b0, 1'b1, 4'h0));
    wait_for(1'b1);
    apb(1'b1, swdt_pkg::FLAG_OFS, 32'h0);
    prot(32'h0);
    $display("test combined done");
    // Fuse forces reset mode, then a second reset
    always_on_fuse <= 1'b1;
    repeat (6) @(posedge pclk);
    prot(ctrl_exp(1'b1, 1'b0, 4'h0));
    rdchk("fuse lock", swdt_pkg::CTRL_OFS, ctrl_exp(1'b0, 1'b1, 4'h0));
    wait_for(1'b1);
    presetn <= 1'b0;
    always_on_fuse <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("ctrl after reset", swdt_pkg::CTRL_OFS, 32'h0);
    $display("test fuse done");
    conclude();
  end
endmodule
`default_nettype wire
